/* File: shared/tstmc_pkg.sv */
// Constants, register layout and types of the two-signal T muting supervisor.
package tstmc_pkg;

    // ------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------
    localparam int CLK_MHZ     = 100;
    localparam int TICK_US     = 1000;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam logic [25:0] MS_PER_S   = 26'h00003e8;
    localparam logic [25:0] MS_PER_MIN = 26'h000ea60;

    // ------------------------------------------------------------
    // Register map (word index = byte address / 4)
    // ------------------------------------------------------------
    localparam logic [2:0] IDX_LIM  = 3'h4;
    localparam logic [2:0] IDX_STAT = 3'h5;
    localparam logic [2:0] IDX_IRQ  = 3'h6;
    localparam logic [2:0] IDX_MASK = 3'h7;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    localparam logic [4:0][31:0] CFG_RST  = '{32'h00020258, 32'h07d00000, 32'h00000000,
                                              32'h00040064, 32'h00000000};
    localparam logic [4:0][31:0] CFG_MASK = '{32'h71ffffff, 32'h0fff03ff, 32'h03ff03ff,
                                              32'h001f03ff, 32'h0000003f};

    // ------------------------------------------------------------
    // Interrupt event positions
    // ------------------------------------------------------------
    localparam int NEV        = 6;
    localparam int EV_START   = 0;
    localparam int EV_END     = 1;
    localparam int EV_REJECT  = 2;
    localparam int EV_TMO     = 3;
    localparam int EV_OVR_END = 4;
    localparam int EV_LAMP    = 5;

    // Configuration words, word 4 first.
    typedef struct packed {
        logic        r4a;
        logic [2:0]  tol;
        logic [2:0]  r4b;
        logic [8:0]  ovr_min;
        logic [15:0] tmo;
        logic [3:0]  r3a;
        logic [11:0] teach;
        logic [5:0]  r3b;
        logic [9:0]  dly;
        logic [5:0]  r2a;
        logic [9:0]  act;
        logic [5:0]  r2b;
        logic [9:0]  deact;
        logic [10:0] r1a;
        logic [4:0]  gmax;
        logic [5:0]  r1b;
        logic [9:0]  gmin;
        logic [25:0] r0;
        logic        inf;
        logic        manual;
        logic        ovr_edge;
        logic        lamp;
        logic        top;
        logic        dyn;
    } tstmc_cfg_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ONE  = 3'b001,
        ST_MUTE = 3'b010,
        ST_HOLD = 3'b011,
        ST_LOCK = 3'b100,
        ST_OVR  = 3'b101,
        ST_ILK  = 3'b110
    } tstmc_state_type;

endpackage : tstmc_pkg

/* File: hdl/tstmc_top.sv */
// Two-signal T muting supervisor with AXI4-Lite registers and interrupt.
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module tstmc_top #(
    parameter int ADDR_W      = 8,
    parameter int BEAMS       = 32,
    parameter int TICK_CYCLES = tstmc_pkg::TICK_CYCLES
) (
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    input  wire logic             first_mute_input_i,
    input  wire logic             second_mute_input_i,
    input  wire logic             override_i,
    input  wire logic             restart_i,
    input  wire logic             lamp_ok_i,
    input  wire logic             curtain_on_i,
    input  wire logic [BEAMS-1:0] beams_i,
    output logic                  muting_o,
    output logic                  override_active_o,
    output logic                  safety_o,
    output logic                  interlock_o,
    output logic                  lamp_fault_o,
    output logic                  irq_o,
    input  wire logic [ADDR_W-1:0] axi_awaddr_i,
    input  wire logic             axi_awvalid_i,
    output logic                  axi_awready_o,
    input  wire logic [31:0]      axi_wdata_i,
    input  wire logic [3:0]       axi_wstrb_i,
    input  wire logic             axi_wvalid_i,
    output logic                  axi_wready_o,
    output logic [1:0]            axi_bresp_o,
    output logic                  axi_bvalid_o,
    input  wire logic             axi_bready_i,
    input  wire logic [ADDR_W-1:0] axi_araddr_i,
    input  wire logic             axi_arvalid_i,
    output logic                  axi_arready_o,
    output logic [31:0]           axi_rdata_o,
    output logic [1:0]            axi_rresp_o,
    output logic                  axi_rvalid_o,
    input  wire logic             axi_rready_i
);

    typedef struct packed {
        logic [4:0][31:0]          cfgw;
        tstmc_pkg::tstmc_state_type st;
        logic [4:0]                sy1;
        logic [4:0]                sy2;
        logic [4:0]                sy3;
        logic [4:0]                in_q;
        logic [1:0]                f;
        logic [1:0][9:0]           fc;
        logic [31:0]               tick_cnt;
        logic                      tick;
        logic [25:0]               cnt;
        logic [11:0]               tcnt;
        logic                      taught;
        logic [5:0]                maxh;
        logic                      lamp_flt;
        logic                      ovr_prev;
        logic                      rst_prev;
        logic [tstmc_pkg::NEV-1:0] stat;
        logic [tstmc_pkg::NEV-1:0] mask;
        logic                      aw_got;
        logic                      w_got;
        logic [ADDR_W-1:0]         awaddr;
        logic [31:0]               wdata;
        logic [3:0]                wstrb;
        logic                      aw_rdy;
        logic                      w_rdy;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      ar_rdy;
        logic                      rvalid;
        logic [31:0]               rdata;
        logic [1:0]                rresp;
        logic                      mute;
        logic                      ovr;
        logic                      safe;
        logic                      ilk;
        logic                      irq;
    } tstmc_core_type;

    tstmc_core_type            r;
    tstmc_core_type            next_r;
    tstmc_pkg::tstmc_cfg_type  c;
    logic [tstmc_pkg::NEV-1:0] ev;
    logic [tstmc_pkg::NEV-1:0] clr;
    logic [BEAMS-1:0]          bv;
    logic [5:0]                hgt;
    logic [25:0]               gmin;
    logic [25:0]               gmax;
    logic [25:0]               tmo_ms;
    logic [25:0]               ovr_ms;
    logic [9:0]                lim;
    logic                      both;
    logic                      any;
    logic                      ovr_rise;
    logic                      rst_rise;
    logic [2:0]                widx;
    logic [2:0]                ridx;
    logic                      wbad;
    logic                      rbad;

    function automatic logic [31:0] tstmc_merge(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction : tstmc_merge

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        c      = r.cfgw;
        ev     = '0;
        clr    = '0;
        gmin   = 26'(c.gmin);
        gmax   = 26'(26'(c.gmax) * tstmc_pkg::MS_PER_S);
        tmo_ms = 26'(26'(c.tmo) * tstmc_pkg::MS_PER_S);
        ovr_ms = 26'(26'(c.ovr_min) * tstmc_pkg::MS_PER_MIN);
        both   = (r.f == 2'h3);
        any    = |r.f;
        ovr_rise = r.in_q[2] & ~r.ovr_prev;
        rst_rise = r.in_q[3] & ~r.rst_prev;
        next_r.ovr_prev = r.in_q[2];
        next_r.rst_prev = r.in_q[3];
        lim    = '0;

        // Mute, override, restart and lamp inputs take three stages; a level counts once stages two and three agree.
        next_r.sy1 = {lamp_ok_i, restart_i, override_i, second_mute_input_i, first_mute_input_i};
        next_r.sy2 = r.sy1;
        next_r.sy3 = r.sy2;
        for (int i = 0; i < 5; i++) begin
            if (r.sy2[i] == r.sy3[i]) begin
                next_r.in_q[i] = r.sy2[i];
            end
        end

        next_r.tick = 1'b0;
        if (r.tick_cnt == 32'(TICK_CYCLES - 1)) begin
            next_r.tick_cnt = '0;
            next_r.tick     = 1'b1;
        end else begin
            next_r.tick_cnt = r.tick_cnt + 32'h1;
        end
        if (r.tick) begin
            next_r.cnt = r.cnt + 26'h1;
        end

        for (int i = 0; i < 2; i++) begin
            lim = r.f[i] ? c.deact : c.act;
            if (r.in_q[i] != r.f[i]) begin
                if (r.fc[i] >= lim) begin
                    next_r.f[i]  = r.in_q[i];
                    next_r.fc[i] = '0;
                end else if (r.tick) begin
                    next_r.fc[i] = r.fc[i] + 10'h1;
                end
            end else begin
                next_r.fc[i] = '0;
            end
        end

        // Beam order reversed for inverted mounting.
        hgt = '0;
        for (int b = 0; b < BEAMS; b++) begin
            bv[b] = c.top ? beams_i[BEAMS-1-b] : beams_i[b];
            if (bv[b]) begin
                hgt = 6'(b + 1);
            end
        end

        next_r.lamp_flt = c.lamp & ~r.in_q[4];
        ev[tstmc_pkg::EV_LAMP] = next_r.lamp_flt & ~r.lamp_flt;

        unique case (r.st)
            tstmc_pkg::ST_IDLE: begin
                next_r.cnt = '0;
                if (ovr_rise) begin
                    next_r.st = tstmc_pkg::ST_OVR;
                end else if (curtain_on_i && !r.lamp_flt && any) begin
                    if (!both) begin
                        next_r.st = tstmc_pkg::ST_ONE;
                    end else if (gmin == 26'h0) begin
                        next_r.st = tstmc_pkg::ST_MUTE;
                        ev[tstmc_pkg::EV_START] = 1'b1;
                    end else begin
                        next_r.st = tstmc_pkg::ST_LOCK;
                        ev[tstmc_pkg::EV_REJECT] = 1'b1;
                    end
                    next_r.tcnt   = '0;
                    next_r.taught = 1'b0;
                    next_r.maxh   = '0;
                end
            end
            tstmc_pkg::ST_ONE: begin
                if (!any) begin
                    next_r.st = tstmc_pkg::ST_IDLE;
                end else if (r.cnt >= gmax) begin
                    next_r.st = tstmc_pkg::ST_LOCK;
                    ev[tstmc_pkg::EV_REJECT] = 1'b1;
                end else if (both && r.cnt < gmin) begin
                    next_r.st = tstmc_pkg::ST_LOCK;
                    ev[tstmc_pkg::EV_REJECT] = 1'b1;
                end else if (both) begin
                    next_r.st  = tstmc_pkg::ST_MUTE;
                    next_r.cnt = '0;
                    ev[tstmc_pkg::EV_START] = 1'b1;
                end
            end
            tstmc_pkg::ST_MUTE: begin
                if (!r.taught) begin
                    if (hgt > r.maxh) begin
                        next_r.maxh = hgt;
                    end
                    if (r.tick) begin
                        next_r.tcnt = r.tcnt + 12'h1;
                    end
                    next_r.taught = (r.tcnt >= c.teach);
                end
                if (!both) begin
                    next_r.st  = (c.dly == 10'h0) ? tstmc_pkg::ST_LOCK : tstmc_pkg::ST_HOLD;
                    next_r.cnt = '0;
                    ev[tstmc_pkg::EV_END] = (c.dly == 10'h0);
                end else if (!c.inf && r.cnt >= tmo_ms) begin
                    next_r.st = tstmc_pkg::ST_LOCK;
                    ev[tstmc_pkg::EV_TMO] = 1'b1;
                // Intrusion over taught height plus tolerance.
                end else if (c.dyn && r.taught && 7'(hgt) > 7'(r.maxh) + 7'(c.tol)) begin
                    next_r.st = tstmc_pkg::ST_LOCK;
                    ev[tstmc_pkg::EV_END] = 1'b1;
                end
            end
            tstmc_pkg::ST_HOLD: begin
                if (r.cnt >= 26'(c.dly)) begin
                    next_r.st = tstmc_pkg::ST_LOCK;
                    ev[tstmc_pkg::EV_END] = 1'b1;
                end
            end
            tstmc_pkg::ST_LOCK: begin
                next_r.cnt = '0;
                if (ovr_rise) begin
                    next_r.st = tstmc_pkg::ST_OVR;
                end else if (!any) begin
                    next_r.st = tstmc_pkg::ST_IDLE;
                end
            end
            tstmc_pkg::ST_OVR: begin
                if (r.cnt >= ovr_ms || (!c.ovr_edge && !r.in_q[2])) begin
                    ev[tstmc_pkg::EV_OVR_END] = 1'b1;
                    next_r.st = c.manual ? tstmc_pkg::ST_ILK : tstmc_pkg::ST_IDLE;
                end
            end
            tstmc_pkg::ST_ILK: begin
                if (rst_rise) begin
                    next_r.st = tstmc_pkg::ST_IDLE;
                end
            end
            default: begin
                next_r.st = tstmc_pkg::ST_IDLE;
            end
        endcase

        next_r.mute = (next_r.st == tstmc_pkg::ST_MUTE) || (next_r.st == tstmc_pkg::ST_HOLD);
        next_r.ovr  = (next_r.st == tstmc_pkg::ST_OVR);
        next_r.ilk  = (next_r.st == tstmc_pkg::ST_ILK);
        next_r.safe = !next_r.ilk && (curtain_on_i || next_r.mute || next_r.ovr);

        // ------------------------------------------------------------
        // AXI4-Lite slave
        // ------------------------------------------------------------
        widx = r.awaddr[4:2];
        wbad = |r.awaddr[ADDR_W-1:5];
        ridx = axi_araddr_i[4:2];
        rbad = |axi_araddr_i[ADDR_W-1:5];
        if (axi_awvalid_i && r.aw_rdy) begin
            next_r.aw_got = 1'b1;
            next_r.awaddr = axi_awaddr_i;
        end
        if (axi_wvalid_i && r.w_rdy) begin
            next_r.w_got = 1'b1;
            next_r.wdata = axi_wdata_i;
            next_r.wstrb = axi_wstrb_i;
        end
        if (r.bvalid && axi_bready_i) begin
            next_r.bvalid = 1'b0;
        end
        if (r.aw_got && r.w_got && !r.bvalid) begin
            next_r.aw_got = 1'b0;
            next_r.w_got  = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp  = wbad ? tstmc_pkg::RESP_ERR : tstmc_pkg::RESP_OK;
            if (!wbad && widx <= tstmc_pkg::IDX_LIM) begin
                next_r.cfgw[widx] = tstmc_merge(r.cfgw[widx], r.wdata, r.wstrb) & tstmc_pkg::CFG_MASK[widx];
            end else if (!wbad && widx == tstmc_pkg::IDX_IRQ) begin
                clr = tstmc_pkg::NEV'(tstmc_merge(32'h0, r.wdata, r.wstrb));
            end else if (!wbad && widx == tstmc_pkg::IDX_MASK) begin
                next_r.mask = tstmc_pkg::NEV'(tstmc_merge(32'(r.mask), r.wdata, r.wstrb));
            end
        end
        next_r.aw_rdy = !next_r.aw_got && !next_r.bvalid;
        next_r.w_rdy  = !next_r.w_got && !next_r.bvalid;

        if (r.rvalid && axi_rready_i) begin
            next_r.rvalid = 1'b0;
        end
        if (axi_arvalid_i && r.ar_rdy) begin
            next_r.rvalid = 1'b1;
            next_r.rresp  = rbad ? tstmc_pkg::RESP_ERR : tstmc_pkg::RESP_OK;
            next_r.rdata  = '0;
            if (!rbad && ridx <= tstmc_pkg::IDX_LIM) begin
                next_r.rdata = r.cfgw[ridx];
            end else if (!rbad && ridx == tstmc_pkg::IDX_STAT) begin
                next_r.rdata = {19'h0, r.taught, r.lamp_flt, r.maxh, r.f, r.st};
            end else if (!rbad && ridx == tstmc_pkg::IDX_IRQ) begin
                next_r.rdata = 32'(r.stat);
            end else if (!rbad) begin
                next_r.rdata = 32'(r.mask);
            end
        end
        next_r.ar_rdy = !next_r.rvalid;

        // Sticky events: a new event wins over a clear in the same cycle.
        next_r.stat = (r.stat & ~clr) | ev;
        next_r.irq  = |(next_r.stat & next_r.mask);
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            r      <= '0;
            r.cfgw <= tstmc_pkg::CFG_RST;
        end else begin
            r <= next_r;
        end
    end

    assign muting_o          = r.mute;
    assign override_active_o = r.ovr;
    assign safety_o          = r.safe;
    assign interlock_o       = r.ilk;
    assign lamp_fault_o      = r.lamp_flt;
    assign irq_o             = r.irq;
    assign axi_awready_o     = r.aw_rdy;
    assign axi_wready_o      = r.w_rdy;
    assign axi_bvalid_o      = r.bvalid;
    assign axi_bresp_o       = r.bresp;
    assign axi_arready_o     = r.ar_rdy;
    assign axi_rvalid_o      = r.rvalid;
    assign axi_rdata_o       = r.rdata;
    assign axi_rresp_o       = r.rresp;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence one_wait_s;
        r.st == tstmc_pkg::ST_ONE ##1 r.st == tstmc_pkg::ST_MUTE;
    endsequence

    mute_start_a:
        assert property (one_wait_s |-> $past(r.f, 1) == 2'h3 && $past(r.cnt, 1) < $past(gmax, 1))
        else $error("muting began without a valid pair");
    on_only_a:
        assert property (r.st == tstmc_pkg::ST_IDLE && !(r.f == 2'h3 && curtain_on_i)
                         |=> r.st != tstmc_pkg::ST_MUTE)
        else $error("muting began while curtain off");
    mute_end_a:
        assert property (r.st == tstmc_pkg::ST_MUTE && r.f != 2'h3 && c.dly == 10'h0 |=> !r.mute)
        else $error("muting held after input dropped");
    hold_time_a:
        assert property (r.st == tstmc_pkg::ST_MUTE && r.f != 2'h3 && c.dly != 10'h0 |=> r.mute [*2])
        else $error("extra hold not applied");
    gap_min_a:
        assert property (r.st == tstmc_pkg::ST_ONE && r.f == 2'h3 && r.cnt < gmin |=> r.st == tstmc_pkg::ST_LOCK)
        else $error("short gap accepted");
    gap_max_a:
        assert property (r.st == tstmc_pkg::ST_ONE && r.f != 2'h0 && r.cnt >= gmax |=> r.st == tstmc_pkg::ST_LOCK)
        else $error("long gap accepted");
    deact_filt_a:
        assert property ($fell(r.f[0]) |-> $past(r.fc[0]) >= $past(c.deact))
        else $error("deactivation filter too short");
    act_filt_a:
        assert property ($rose(r.f[1]) |-> $past(r.fc[1]) >= $past(c.act))
        else $error("activation filter too short");
    dyn_limit_a:
        assert property (r.st == tstmc_pkg::ST_MUTE && r.f == 2'h3 && c.dyn && r.taught
                         && 7'(hgt) > 7'(r.maxh) + 7'(c.tol) |=> !r.mute)
        else $error("beam tolerance exceeded during muting");
    ovr_level_a:
        assert property (r.st == tstmc_pkg::ST_OVR && !c.ovr_edge && !r.in_q[2] |=> !r.ovr)
        else $error("level override not ended");
    ovr_edge_a:
        assert property (r.st == tstmc_pkg::ST_OVR && c.ovr_edge && r.cnt < ovr_ms |=> r.ovr)
        else $error("edge override ended early");
    interlock_a:
        assert property (r.ilk |-> !safety_o ##1 (r.ilk || $past(rst_rise)))
        else $error("interlock left without restart");
    mute_tmo_a:
        assert property (r.st == tstmc_pkg::ST_MUTE && r.f == 2'h3 && !c.inf && r.cnt >= tmo_ms |=> !r.mute)
        else $error("muting outlived its duration");

endmodule : tstmc_top

/* File: bench/tstmc_sensors.sv */
// Behavioural model of the muting presence sensors.
`timescale 1ns/1ps
module tstmc_sensors (
    input  wire logic        clock_i,
    input  wire logic        go_i,
    input  wire logic        rev_i,
    input  wire logic [15:0] gap_i,
    input  wire logic [15:0] hold_i,
    output logic             first_mute_input_o,
    output logic             second_mute_input_o,
    output logic             busy_o
);
    logic [16:0] cnt = 17'h0;
    initial begin
        first_mute_input_o = 1'b0;
        second_mute_input_o = 1'b0;
        busy_o = 1'b0;
    end
    always @(posedge clock_i) begin
        if (go_i && !busy_o) begin
            busy_o <= 1'b1;
            cnt <= 17'h0;
            if (rev_i) second_mute_input_o <= 1'b1;
            else first_mute_input_o <= 1'b1;
        end else if (busy_o) begin
            cnt <= cnt + 17'h1;
            if (cnt == 17'(gap_i)) begin
                first_mute_input_o <= 1'b1;
                second_mute_input_o <= 1'b1;
            end
            if (cnt == 17'(gap_i) + 17'(hold_i)) begin
                first_mute_input_o <= 1'b0;
                second_mute_input_o <= 1'b0;
                busy_o <= 1'b0;
            end
        end
    end
endmodule : tstmc_sensors

/* File: bench/tb.sv */
// Testbench of the two-signal T muting supervisor.
`timescale 1ns/1ps
module tb;
    logic clock_i = 0, rst_i = 1, go = 0, rev = 0, curt = 1, seen = 0, ovr = 0, rs = 0;
    logic aw = 0, w = 0, br = 0, ar = 0, rr = 0, m1, m2, busy, mut, irq, awr, wr, bv, arr, rv;
    logic ov, ilk, safe;
    logic [15:0] gap = 16'h0;
    logic [7:0] awa = 8'h0, ara = 8'h0;
    logic [31:0] wd = 32'h0, rd;
    logic [1:0] bre, rre;
    int error_cnt = 0, compares = 0;
    always #5 clock_i = ~clock_i;
    always @(posedge clock_i) if (mut === 1'b1) seen <= 1'b1;
    tstmc_sensors ps (.clock_i(clock_i), .go_i(go), .rev_i(rev), .gap_i(gap), .hold_i(16'h00c8),
        .first_mute_input_o(m1), .second_mute_input_o(m2), .busy_o(busy));
    tstmc_top #(.TICK_CYCLES(10)) dut (.clock_i(clock_i), .rst_i(rst_i), .first_mute_input_i(m1),
        .second_mute_input_i(m2), .override_i(ovr), .restart_i(rs), .lamp_ok_i(1'b1),
        .curtain_on_i(curt), .beams_i(32'h0), .muting_o(mut), .override_active_o(ov), .safety_o(safe),
        .interlock_o(ilk), .lamp_fault_o(), .irq_o(irq), .axi_awaddr_i(awa), .axi_awvalid_i(aw),
        .axi_awready_o(awr), .axi_wdata_i(wd), .axi_wstrb_i(4'hf), .axi_wvalid_i(w),
        .axi_wready_o(wr), .axi_bresp_o(bre), .axi_bvalid_o(bv), .axi_bready_i(br),
        .axi_araddr_i(ara), .axi_arvalid_i(ar), .axi_arready_o(arr), .axi_rdata_o(rd),
        .axi_rresp_o(rre), .axi_rvalid_o(rv), .axi_rready_i(rr));
    task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask : bound
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clock_i) begin awa <= a; wd <= d; aw <= 1; w <= 1; br <= 1; end
        for (n = 0; n < 100; n++) begin
            @(posedge clock_i);
            if (awr === 1'b1) aw <= 0;
            if (wr === 1'b1) w <= 0;
            if (bv === 1'b1) break;
        end
        bound(n, 100);
        br <= 0;
        check("bresp", {30'h0, bre}, {30'h0, er});
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        @(posedge clock_i) begin ara <= a; ar <= 1; rr <= 1; end
        for (n = 0; n < 100; n++) begin
            @(posedge clock_i);
            if (arr === 1'b1) ar <= 0;
            if (rv === 1'b1) break;
        end
        bound(n, 100);
        rr <= 0;
        check("rresp", {30'h0, rre}, {30'h0, er});
        check("rdata", rd, e);
    endtask : rd_reg
    task automatic pass(input string n, input logic r, input logic [15:0] g, input logic e);
        int i;
        seen = 0;
        @(posedge clock_i) begin rev <= r; gap <= g; go <= 1; end
        @(posedge clock_i) go <= 0;
        @(posedge clock_i);
        for (i = 0; i < 12000 && busy === 1'b1; i++) @(posedge clock_i);
        bound(i, 12000);
        repeat (30) @(posedge clock_i);
        check({n, " muted"}, {31'h0, seen}, {31'h0, e});
        check({n, " ended"}, {31'h0, mut}, 32'h0);
        $display("test %s done", n);
    endtask : pass
    initial begin
        repeat (3) @(posedge clock_i);
        rst_i <= 0;
        repeat (2) @(posedge clock_i);
        rd_reg(8'h04, 32'h00040064, 2'h0);
        rd_reg(8'h08, 32'h00000000, 2'h0);
        rd_reg(8'h0c, 32'h07d00000, 2'h0);
        wr_reg(8'h04, 32'h00010002, 2'h0);
        wr_reg(8'h1c, 32'h00000004, 2'h0);
        pass("forward", 1'b0, 16'h0032, 1'b1);
        pass("reverse", 1'b1, 16'h0032, 1'b1);
        rd_reg(8'h18, 32'h00000003, 2'h0);
        check("irq masked", {31'h0, irq}, 32'h0);
        pass("short gap", 1'b0, 16'h0005, 1'b0);
        check("irq raised", {31'h0, irq}, 32'h1);
        wr_reg(8'h18, 32'h0000003f, 2'h0);
        rd_reg(8'h18, 32'h00000000, 2'h0);
        check("irq cleared", {31'h0, irq}, 32'h0);
        pass("long gap", 1'b1, 16'h2968, 1'b0);
        @(posedge clock_i) curt <= 0;
        pass("curtain off", 1'b0, 16'h0032, 1'b0);
        curt <= 1;
        ovr <= 1;
        repeat (10) @(posedge clock_i);
        check("level override on", {31'h0, ov}, 32'h1);
        ovr <= 0;
        repeat (10) @(posedge clock_i);
        check("level override off", {31'h0, ov}, 32'h0);
        check("auto restart safety", {31'h0, safe}, 32'h1);
        $display("test level override done");
        wr_reg(8'h00, 32'h00000018, 2'h0);
        ovr <= 1;
        repeat (10) @(posedge clock_i);
        ovr <= 0;
        repeat (10) @(posedge clock_i);
        check("edge override held", {31'h0, ov}, 32'h1);
        wr_reg(8'h10, 32'h00000258, 2'h0);
        repeat (3) @(posedge clock_i);
        check("override expired", {31'h0, ov}, 32'h0);
        check("interlock on", {31'h0, ilk}, 32'h1);
        check("interlock safety", {31'h0, safe}, 32'h0);
        rs <= 1;
        repeat (10) @(posedge clock_i);
        rs <= 0;
        repeat (10) @(posedge clock_i);
        check("interlock left", {31'h0, ilk}, 32'h0);
        check("restart safety", {31'h0, safe}, 32'h1);
        $display("test edge override done");
        rd_reg(8'h20, 32'h00000000, 2'h2);
        tally_and_finish();
    end
endmodule : tb
